// >>> src/sgm_params.svh
// Register map, field positions, reset values and masks of the
// signal measurement timer control block.
// Assumes inclusion by bare name from the design files that need it.
`ifndef SGM_PARAMS_SVH
`define SGM_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------
`define SGM_OFF_CTL_A 8'h00
`define SGM_OFF_CTL_B 8'h04
`define SGM_OFF_STATUS 8'h08
`define SGM_OFF_CLK_SEL 8'h0c
`define SGM_OFF_WIN_SEL 8'h10
`define SGM_OFF_SIG_SEL 8'h14
`define SGM_OFF_CNT_LOW 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SGM_EN_BIT 7
`define SGM_HALT_BIT 5
`define SGM_WINDOW_POLARITY_BIT 4
`define SGM_SIGNAL_POLARITY_BIT 3
`define SGM_CEDGE_BIT 2
`define SGM_GO_BIT 7
`define SGM_REPEAT_BIT 6
`define SGM_PLOAD_BIT 7
`define SGM_WLOAD_BIT 6
`define SGM_CCLR_BIT 5
`define SGM_TS_BIT 2
`define SGM_WS_BIT 1
`define SGM_AS_BIT 0

// ----------------------------------------------------------------
// Reset values, writable mask, last mode code and reserved source masks
// ----------------------------------------------------------------
`define SGM_REG_RST 8'h00
`define SGM_CNT_RST 24'h000000
`define SGM_CNT_ONE 24'h000001
`define SGM_CTL_A_MASK 8'hbf
`define SGM_MODE_LAST 4'ha
`define SGM_WIN_RSVD 32'hf8060000
`define SGM_SIG_RSVD 32'hfc030000

`endif

// >>> src/sgm_pkg.sv
// Types of the signal measurement timer control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sgm_pkg;

   // -------------------------------------------------------------
   // Operating modes
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      SGM_TIMER = 4'b0000,
      SGM_GATED_TIMER = 4'b0001,
      SGM_PERIOD_DUTY = 4'b0010,
      SGM_HIGH_LOW = 4'b0011,
      SGM_WIN_MEAS = 4'b0100,
      SGM_GATED_WIN = 4'b0101,
      SGM_TIME_FLIGHT = 4'b0110,
      SGM_CAPTURE = 4'b0111,
      SGM_COUNTER = 4'b1000,
      SGM_GATED_CNT = 4'b1001,
      SGM_WIN_CNT = 4'b1010
   } sgm_mode_t;

   // -------------------------------------------------------------
   // Bus request carrier and per-module state
   // -------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sgm_wb_req_t;

   typedef struct packed {
      logic cond_valid;
      logic cond_prev;
   } sgm_edge_st_t;

   typedef struct packed {
      logic [2:0] cnt;
   } sgm_pre_st_t;

   typedef struct packed {
      logic [7:0] ctl_a;
      logic go;
      logic rep;
      logic [3:0] mode;
      logic [2:0] req;
      logic [2:0] csel;
      logic [4:0] wsel;
      logic [4:0] ssel;
      logic [23:0] count;
      logic [23:0] pcap;
      logic [23:0] wcap;
      logic armed;
      logic ack;
      logic [7:0] rdata;
      logic ev_match;
      logic ev_pacq;
      logic ev_wacq;
   } sgm_state_t;

endpackage : sgm_pkg

// >>> src/sgm_edge.sv
// Polarity conditioner and edge finder for one synchronous input.
// Assumes the input is already synchronous to CLK.
`timescale 1ns/100ps
module sgm_edge (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLR,
   // Input and polarity
   input wire logic DIN,
   input wire logic INVERT,
   // Conditioned level and edges
   output logic LEVEL,
   output logic RISE,
   output logic FALL
);
   import sgm_pkg::*;

   sgm_edge_st_t st_reg;
   sgm_edge_st_t st_next;

   // Active level after polarity
   assign LEVEL = DIN ^ INVERT;
   assign RISE = st_reg.cond_valid & LEVEL & ~st_reg.cond_prev;
   assign FALL = st_reg.cond_valid & ~LEVEL & st_reg.cond_prev;

   // History; cleared while the block is disabled
   always_comb begin
      st_next = st_reg;
      st_next.cond_prev = LEVEL;
      st_next.cond_valid = ~CLR;
   end

   // State register
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : sgm_edge

// >>> src/sgm_prescale.sv
// Divides a stream of counting-edge ticks by 1, 2, 4 or 8.
// Assumes one tick lasts one CLK cycle.
`timescale 1ns/100ps
module sgm_prescale (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLR,
   // Ticks and ratio
   input wire logic TICK_IN,
   input wire logic [1:0] RATIO,
   output logic TICK_OUT
);
   import sgm_pkg::*;

   sgm_pre_st_t st_reg;
   sgm_pre_st_t st_next;
   logic [2:0] mask;

   // Pass every 2**RATIO-th tick
   always_comb begin
      case (RATIO)
         2'b00: mask = 3'h0;
         2'b01: mask = 3'h1;
         2'b10: mask = 3'h3;
         default: mask = 3'h7;
      endcase
      TICK_OUT = TICK_IN & ((st_reg.cnt & mask) == mask);
      st_next = st_reg;
      if (CLR) begin
         st_next.cnt = 3'h0;
      end else if (TICK_IN) begin
         st_next.cnt = st_reg.cnt + 3'h1;
      end
   end

   // State register
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : sgm_prescale

// >>> src/sgm_regs.sv
// Signal measurement timer: register file, counter and mode engine.
// Assumes classic Wishbone master on CLK and synchronous source inputs.
//
// How it works
// - Enable clear resets internal state and drops clock requests.
// - Enable clear leaves all software registers untouched.
// - Halt set: counter holds at limit on match, match event raised.
// - Halt clear: counter wraps to zero on match, match event raised.
// - Window polarity picks active-low falling or active-high rising.
// - Signal polarity picks active-low falling or active-high rising.
// - Clock edge bit picks falling or rising counting edge.
// - Prescale field divides counting ticks by 1, 2, 4 or 8.
// - Run bit allows counting; hardware clears it after single run.
// - Repeat bit picks continuous or single acquisition.
// - Mode field picks one of eleven operations; rest reserved.
// - Manual period load copies counter, then clears itself.
// - Manual width load copies counter, then clears itself.
// - Manual counter clear zeroes counter, then clears itself.
// - Counting flag reads one while counter may advance.
// - Window flag reads one while window is open; reads zero while disabled.
// - Acquisition flag reads one while acquisition runs.
// - Three-bit field selects one of eight counting clocks.
// - Five-bit field routes window source; reserved codes read low.
// - Five-bit field routes signal source; reserved codes read low.
// - Counter low byte is read/write and resets to zero.
// - Unimplemented register bits read zero and ignore writes.
// - Timer mode counts while running, ignoring window and signal.
// - Capture updates raise width and period acquisition events.
// - Counter modes count signal pulses, not the counting clock.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "sgm_params.svh"
module sgm_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Wishbone slave
   input sgm_pkg::sgm_wb_req_t WB_REQ,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK,
   // Sources and match limit
   input wire logic [7:0] CLK_SRC,
   input wire logic [31:0] WIN_SRC,
   input wire logic [31:0] SIG_SRC,
   input wire logic [23:0] MATCH_LIMIT,
   // Counter and captures
   output logic [23:0] COUNT_VALUE,
   output logic [23:0] PERIOD_CAPTURE,
   output logic [23:0] WIDTH_CAPTURE,
   // Events and clock requests
   output logic PERIOD_MATCH_EVT,
   output logic PERIOD_ACQ_EVT,
   output logic WIDTH_ACQ_EVT,
   output logic [7:0] CLOCK_REQ
);
   import sgm_pkg::*;

   sgm_state_t s_reg;
   sgm_state_t s_next;
   logic en, run, mode_ok, clr_int, acc, wr;
   logic win_lvl, win_rise, win_fall;
   logic sig_lvl, sig_rise, sig_fall;
   logic clk_edge, pre_tick;
   logic inc, do_p, do_w, rst_c, load1, arm_set, arm_clr, end_acq;
   logic needs_arm, ts_flag;
   logic [7:0] stat_rd;

   // ----------------------------------------------------------------
   // Source selection and edge conditioning
   // ----------------------------------------------------------------
   assign en = s_reg.ctl_a[`SGM_EN_BIT];
   assign clr_int = ~en;
   assign mode_ok = (s_reg.mode <= `SGM_MODE_LAST);
   assign run = en & s_reg.go & mode_ok;

   // Window input conditioner
   sgm_edge u_win (
      .CLK(CLK),
      .RST(RST),
      .CLR(clr_int),
      .DIN(|(WIN_SRC & ~`SGM_WIN_RSVD & (32'h1 << s_reg.wsel))),
      .INVERT(s_reg.ctl_a[`SGM_WINDOW_POLARITY_BIT]),
      .LEVEL(win_lvl),
      .RISE(win_rise),
      .FALL(win_fall)
   );

   // Signal input conditioner
   sgm_edge u_sig (
      .CLK(CLK),
      .RST(RST),
      .CLR(clr_int),
      .DIN(|(SIG_SRC & ~`SGM_SIG_RSVD & (32'h1 << s_reg.ssel))),
      .INVERT(s_reg.ctl_a[`SGM_SIGNAL_POLARITY_BIT]),
      .LEVEL(sig_lvl),
      .RISE(sig_rise),
      .FALL(sig_fall)
   );

   // Counting clock: selected source, chosen edge
   sgm_edge u_clk (
      .CLK(CLK),
      .RST(RST),
      .CLR(clr_int),
      .DIN(CLK_SRC[s_reg.csel]),
      .INVERT(s_reg.ctl_a[`SGM_CEDGE_BIT]),
      .LEVEL(),
      .RISE(clk_edge),
      .FALL()
   );

   // Prescaler on the counting edge
   sgm_prescale u_pre (
      .CLK(CLK),
      .RST(RST),
      .CLR(clr_int),
      .TICK_IN(clk_edge),
      .RATIO(s_reg.ctl_a[1:0]),
      .TICK_OUT(pre_tick)
   );

   // ----------------------------------------------------------------
   // Mode engine
   // ----------------------------------------------------------------
   // Count enables and capture strobes per mode
   always_comb begin
      inc = 1'b0;
      do_p = 1'b0;
      do_w = 1'b0;
      rst_c = 1'b0;
      load1 = 1'b0;
      arm_set = 1'b0;
      arm_clr = 1'b0;
      if (run) begin
         case (s_reg.mode)
            SGM_TIMER: inc = pre_tick;
            SGM_GATED_TIMER: begin
               inc = pre_tick & sig_lvl;
               do_w = sig_fall;
            end
            SGM_PERIOD_DUTY: begin
               inc = pre_tick;
               do_w = sig_fall;
               do_p = sig_rise;
               load1 = sig_rise;
            end
            SGM_HIGH_LOW: begin
               inc = pre_tick;
               do_w = sig_fall;
               do_p = sig_rise;
               rst_c = sig_rise | sig_fall;
            end
            SGM_WIN_MEAS, SGM_GATED_WIN: begin
               inc = pre_tick & s_reg.armed &
                  (sig_lvl | (s_reg.mode == SGM_WIN_MEAS));
               arm_set = win_rise;
               do_p = win_rise & s_reg.armed;
               rst_c = do_p;
            end
            SGM_TIME_FLIGHT: begin
               inc = pre_tick & s_reg.armed;
               arm_set = win_rise;
               do_p = sig_rise & s_reg.armed;
               do_w = win_rise & s_reg.armed & ~sig_rise;
               arm_clr = do_p;
               rst_c = do_p | do_w;
            end
            SGM_CAPTURE: begin
               inc = pre_tick;
               do_p = win_rise;
               do_w = win_fall;
            end
            SGM_COUNTER: begin
               inc = sig_rise;
               do_w = win_rise;
            end
            SGM_GATED_CNT: begin
               inc = sig_rise & win_lvl;
               do_w = win_fall;
            end
            SGM_WIN_CNT: begin
               inc = sig_rise & s_reg.armed;
               arm_set = win_rise;
               do_w = win_fall;
               do_p = win_rise & s_reg.armed;
               rst_c = do_p;
            end
            default: inc = 1'b0;
         endcase
      end
   end

   // Single acquisition ends on its final capture
   assign end_acq = do_p | (do_w & (s_reg.mode == SGM_GATED_TIMER ||
      s_reg.mode == SGM_COUNTER || s_reg.mode == SGM_GATED_CNT));
   assign needs_arm = (s_reg.mode == SGM_WIN_MEAS) ||
      (s_reg.mode == SGM_GATED_WIN) || (s_reg.mode == SGM_TIME_FLIGHT) ||
      (s_reg.mode == SGM_WIN_CNT);
   assign ts_flag = run & (~needs_arm | s_reg.armed);

   // Status byte; bits 4:3 unimplemented
   assign stat_rd = {s_reg.req, 2'b00, ts_flag, en & win_lvl, run};

   // ----------------------------------------------------------------
   // Register file and counter update
   // ----------------------------------------------------------------
   assign acc = WB_REQ.cyc & WB_REQ.stb & ~s_reg.ack;
   assign wr = acc & WB_REQ.we & WB_REQ.sel[0];

   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.ack = acc;
      s_next.ev_match = 1'b0;
      s_next.ev_pacq = 1'b0;
      s_next.ev_wacq = 1'b0;
      // Arming for window-started modes; a new start beats a disarm
      if (~run) begin
         s_next.armed = 1'b0;
      end else if (arm_set) begin
         s_next.armed = 1'b1;
      end else if (arm_clr) begin
         s_next.armed = 1'b0;
      end
      // Counter
      if (s_reg.req[0]) begin
         s_next.count = `SGM_CNT_RST;
         s_next.req[0] = 1'b0;
      end else if (load1) begin
         s_next.count = `SGM_CNT_ONE;
      end else if (rst_c) begin
         s_next.count = `SGM_CNT_RST;
      end else if (inc) begin
         if (s_reg.count == MATCH_LIMIT) begin
            s_next.ev_match = 1'b1;
            if (!s_reg.ctl_a[`SGM_HALT_BIT]) begin
               s_next.count = `SGM_CNT_RST;
            end
         end else begin
            s_next.count = s_reg.count + `SGM_CNT_ONE;
         end
      end
      // Period capture, automatic or manual
      if (s_reg.req[2]) begin
         s_next.req[2] = 1'b0;
      end
      if ((do_p | s_reg.req[2]) & mode_ok) begin
         s_next.pcap = s_reg.count;
         s_next.ev_pacq = 1'b1;
      end
      // Width capture, automatic or manual
      if (s_reg.req[1]) begin
         s_next.req[1] = 1'b0;
      end
      if ((do_w | s_reg.req[1]) & mode_ok) begin
         s_next.wcap = s_reg.count;
         s_next.ev_wacq = 1'b1;
      end
      // Single acquisition stops the run bit
      if (end_acq & ~s_reg.rep) begin
         s_next.go = 1'b0;
      end
      // Software writes; a request set beats its own completion
      if (wr) begin
         case (WB_REQ.adr)
            `SGM_OFF_CTL_A:
               s_next.ctl_a = WB_REQ.dat[7:0] & `SGM_CTL_A_MASK;
            `SGM_OFF_CTL_B: begin
               s_next.go = WB_REQ.dat[`SGM_GO_BIT];
               s_next.rep = WB_REQ.dat[`SGM_REPEAT_BIT];
               s_next.mode = WB_REQ.dat[3:0];
            end
            `SGM_OFF_STATUS:
               s_next.req = s_next.req | WB_REQ.dat[7:5];
            `SGM_OFF_CLK_SEL: s_next.csel = WB_REQ.dat[2:0];
            `SGM_OFF_WIN_SEL: s_next.wsel = WB_REQ.dat[4:0];
            `SGM_OFF_SIG_SEL: s_next.ssel = WB_REQ.dat[4:0];
            `SGM_OFF_CNT_LOW: s_next.count[7:0] = WB_REQ.dat[7:0];
            default: s_next.rdata = s_reg.rdata;
         endcase
      end
      // Read data, zero above the byte and at unmapped offsets
      if (acc) begin
         case (WB_REQ.adr)
            `SGM_OFF_CTL_A: s_next.rdata = s_reg.ctl_a;
            `SGM_OFF_CTL_B:
               s_next.rdata = {s_reg.go, s_reg.rep, 2'b00, s_reg.mode};
            `SGM_OFF_STATUS: s_next.rdata = stat_rd;
            `SGM_OFF_CLK_SEL: s_next.rdata = {5'h00, s_reg.csel};
            `SGM_OFF_WIN_SEL: s_next.rdata = {3'h0, s_reg.wsel};
            `SGM_OFF_SIG_SEL: s_next.rdata = {3'h0, s_reg.ssel};
            `SGM_OFF_CNT_LOW: s_next.rdata = s_reg.count[7:0];
            default: s_next.rdata = 8'h00;
         endcase
      end
   end

   // State register; disable clears only its armed flag, reset clears all of it
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign WB_ACK = s_reg.ack;
   assign WB_DAT_O = {24'h000000, s_reg.rdata};
   assign COUNT_VALUE = s_reg.count;
   assign PERIOD_CAPTURE = s_reg.pcap;
   assign WIDTH_CAPTURE = s_reg.wcap;
   assign PERIOD_MATCH_EVT = s_reg.ev_match;
   assign PERIOD_ACQ_EVT = s_reg.ev_pacq;
   assign WIDTH_ACQ_EVT = s_reg.ev_wacq;
   // One-hot request for the selected clock while enabled
   assign CLOCK_REQ = en ? (8'h01 << s_reg.csel) : 8'h00;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_disable_quiet: assert property (
      !en |-> (CLOCK_REQ == 8'h00) && !ts_flag && !inc)
      else $error("disabled block still active");

   a_disable_keeps: assert property (
      $fell(en) && !wr && !s_reg.req[0] |=> $stable(s_reg.ctl_a) &&
         $stable(s_reg.mode) && $stable(s_reg.csel) && $stable(COUNT_VALUE))
      else $error("disable changed registers");

   a_halt_hold: assert property (
      inc && !s_reg.req[0] && !rst_c && !load1 && !wr &&
      s_reg.ctl_a[`SGM_HALT_BIT] && s_reg.count == MATCH_LIMIT |=>
         PERIOD_MATCH_EVT && COUNT_VALUE == $past(MATCH_LIMIT))
      else $error("halt at match did not hold");

   a_wrap_zero: assert property (
      inc && !s_reg.req[0] && !rst_c && !load1 && !wr &&
      !s_reg.ctl_a[`SGM_HALT_BIT] && s_reg.count == MATCH_LIMIT |=>
         PERIOD_MATCH_EVT && COUNT_VALUE == 24'h000000)
      else $error("match did not wrap to zero");

   a_single_stop: assert property (
      end_acq && !s_reg.rep && !wr |=> !s_reg.go)
      else $error("single acquisition left run set");

   a_pload_done: assert property (
      s_reg.req[2] && mode_ok && !wr |=>
         !s_reg.req[2] && PERIOD_ACQ_EVT &&
         PERIOD_CAPTURE == $past(COUNT_VALUE))
      else $error("manual period load failed");

   a_wload_done: assert property (
      s_reg.req[1] && mode_ok && !wr |=> !s_reg.req[1] ##0 WIDTH_ACQ_EVT)
      else $error("manual width load failed");

   a_clear_done: assert property (
      s_reg.req[0] && !wr |=> COUNT_VALUE == 24'h000000 && !s_reg.req[0])
      else $error("manual counter clear failed");

   a_unimpl_zero: assert property (
      WB_ACK |-> WB_DAT_O[31:8] == 24'h000000 && !s_reg.ctl_a[6])
      else $error("unimplemented bits not zero");

   a_reserved_idle: assert property (
      !mode_ok && !s_reg.req[0] && !wr |=> $stable(COUNT_VALUE) &&
         $stable(PERIOD_CAPTURE) && !PERIOD_MATCH_EVT && !WIDTH_ACQ_EVT)
      else $error("reserved mode changed state");

   a_low_write: assert property (
      wr && WB_REQ.adr == `SGM_OFF_CNT_LOW |=>
         COUNT_VALUE[7:0] == $past(WB_REQ.dat[7:0]))
      else $error("counter low byte write lost");

   c_match: cover property (PERIOD_MATCH_EVT);
   c_period_acq: cover property (do_p ##1 PERIOD_ACQ_EVT);
   c_counter_mode: cover property (s_reg.mode == SGM_COUNTER && inc);
   c_manual_clear: cover property (s_reg.req[0]);

endmodule : sgm_regs

// >>> verif/sgm_src_model.sv
// Model of the on-chip clock, window and signal sources.
// Assumes the bench sets the window and signal levels at CLK edges.
`timescale 1ns/100ps
module sgm_src_model (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Levels from the bench
   input wire logic WIN_LVL,
   input wire logic SIG_LVL,
   // Source buses
   output logic [7:0] CLK_SRC,
   output logic [31:0] WIN_SRC,
   output logic [31:0] SIG_SRC
);
   logic [1:0] div;
   // Clock sources run at CLK/4, below the CLK/2 limit
   always_ff @(posedge CLK) begin
      div <= RST ? 2'h0 : div + 2'h1;
   end
   assign CLK_SRC = {8{div[1]}};
   // Reserved indices carry the level too; the design must mask them
   assign WIN_SRC = {32{WIN_LVL}};
   assign SIG_SRC = {32{SIG_LVL}};
endmodule : sgm_src_model

// >>> verif/tb_signal_measure_timer_regs.sv
// Bench: register access over Wishbone and source-driven counting.
// Assumes the source model and the design files are compiled first.
`timescale 1ns/100ps
`include "sgm_params.svh"
module tb_signal_measure_timer_regs;
   import sgm_pkg::*;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic CLK = 1'b0, RST = 1'b1, win = 1'b0, sig = 1'b0, ack, pm, pa, wa;
   sgm_wb_req_t req = '0;
   logic [31:0] dat_o, rd, wsrc, ssrc;
   logic [7:0] csrc, creq, d;
   logic [23:0] lim = 24'hffffff, cnt, pcap, wcap, c0;
   int bad_count = 0, n_compared = 0, n_pm = 0, n_pa = 0, n_wa = 0, e;
   logic [7:0] offs [5] = '{`SGM_OFF_CTL_B, `SGM_OFF_CLK_SEL,
      `SGM_OFF_WIN_SEL, `SGM_OFF_SIG_SEL, `SGM_OFF_CNT_LOW};
   logic [7:0] msk [5] = '{8'hcf, 8'h07, 8'h1f, 8'h1f, 8'hff};
   sgm_regs u_dut (.CLK(CLK), .RST(RST), .WB_REQ(req), .WB_DAT_O(dat_o),
      .WB_ACK(ack), .CLK_SRC(csrc), .WIN_SRC(wsrc), .SIG_SRC(ssrc),
      .MATCH_LIMIT(lim), .COUNT_VALUE(cnt), .PERIOD_CAPTURE(pcap),
      .WIDTH_CAPTURE(wcap), .PERIOD_MATCH_EVT(pm), .PERIOD_ACQ_EVT(pa),
      .WIDTH_ACQ_EVT(wa), .CLOCK_REQ(creq));
   sgm_src_model u_src (.CLK(CLK), .RST(RST), .WIN_LVL(win),
      .SIG_LVL(sig), .CLK_SRC(csrc), .WIN_SRC(wsrc), .SIG_SRC(ssrc));
   // Clock and event pulse counters, sampled mid-cycle
   initial forever #12.5 CLK = ~CLK;
   always @(negedge CLK) begin
      n_pm += (pm === 1'b1);
      n_pa += (pa === 1'b1);
      n_wa += (wa === 1'b1);
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // One classic cycle; returns at a falling edge
   task automatic wb(input logic w, input logic [7:0] a, dv);
      int n;
      n = 0;
      @(posedge CLK);
      req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, dv}};
      do begin
         @(posedge CLK);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) check(32'h0, 32'h1, "ack wait");
      rd = dat_o;
      req <= '0;
      @(negedge CLK);
   endtask : wb
   task automatic wr(input logic [7:0] a, dv);
      wb(1'b1, a, dv);
   endtask : wr
   task automatic rc(input logic [7:0] a, exp, input string what);
      wb(1'b0, a, 8'h00);
      check(rd, {24'h0, exp}, what);
   endtask : rc
   task automatic cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask : cyc
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge CLK) sig <= 1'b1;
         cyc(3);
         @(posedge CLK) sig <= 1'b0;
         cyc(3);
      end
   endtask : pulse
   task automatic finish_test;
      $display("counts: %0d compared, %0d mismatched", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   // Watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (30000) @(posedge CLK);
      bad_count++;
      finish_test();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(69));
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      // Reset values, including unmapped offset 0x1c
      for (int i = 0; i < 8; i++) rc(8'(i * 4), 8'h00, "reset");
      // Random writes with enable held off, masked read-back
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         wr(`SGM_OFF_CTL_A, d & 8'h7f);
         rc(`SGM_OFF_CTL_A, d & 8'h3f, "control a");
         for (int j = 0; j < 5; j++) begin
            wr(offs[j], d);
            rc(offs[j], d & msk[j], "masked reg");
         end
      end
      for (int m = 0; m < 16; m++) begin
         wr(`SGM_OFF_CTL_B, 8'(m));
         rc(`SGM_OFF_CTL_B, 8'(m), "mode code");
      end
      // Pin sources for the source-driven tests
      wr(`SGM_OFF_WIN_SEL, 8'h00);
      wr(`SGM_OFF_SIG_SEL, 8'h00);
      $display("test registers done");
      // Clock request follows enable and source field
      for (int k = 0; k < 8; k++) begin
         wr(`SGM_OFF_CLK_SEL, 8'(k));
         wr(`SGM_OFF_CTL_A, 8'h80);
         check(creq, 32'(8'h01 << k), "clock request");
         wr(`SGM_OFF_CTL_A, 8'h00);
         check(creq, 32'h0, "request off");
         rc(`SGM_OFF_CLK_SEL, 8'(k), "kept select");
      end
      $display("test enable done");
      // Timer mode at each prescale, random counting edge
      for (int p = 0; p < 4; p++) begin
         wr(`SGM_OFF_CTL_B, 8'h40);
         wr(`SGM_OFF_STATUS, 8'h20);
         cyc(2);
         check(cnt, 32'h0, "manual clear");
         wr(`SGM_OFF_CTL_A, 8'h80 | 8'(p) | (8'($urandom) & 8'h04));
         wr(`SGM_OFF_CTL_B, 8'hc0);
         rc(`SGM_OFF_STATUS, 8'h05, "run flags");
         c0 = cnt;
         cyc(256);
         e = int'(cnt - c0);
         check(32'(e >= (64 >> p) - 1 && e <= (64 >> p) + 1), 1, "rate");
      end
      wr(`SGM_OFF_CTL_B, 8'h40);
      c0 = cnt;
      cyc(20);
      check(cnt, c0, "stopped count");
      $display("test prescale done");
      // Halt at match, then wrap at match
      @(posedge CLK) lim <= 24'h000005;
      wr(`SGM_OFF_STATUS, 8'h20);
      wr(`SGM_OFF_CTL_A, 8'ha0);
      wr(`SGM_OFF_CTL_B, 8'hc0);
      cyc(60);
      e = n_pm;
      cyc(40);
      check(cnt, 32'h5, "halted count");
      check(32'(n_pm - e > 1), 1, "halt matches");
      wr(`SGM_OFF_CTL_A, 8'h80);
      e = n_pm;
      cyc(100);
      check(32'(cnt <= 24'h5 && n_pm - e >= 3), 1, "wrap");
      // Reserved mode freezes counter and events
      wr(`SGM_OFF_CTL_B, 8'hcb);
      c0 = cnt;
      e = n_pm;
      cyc(40);
      check(cnt, c0, "reserved count");
      check(n_pm, e, "reserved events");
      rc(`SGM_OFF_STATUS, 8'h00, "reserved flags");
      $display("test match done");
      // Low byte write, manual captures
      @(posedge CLK) lim <= 24'hffffff;
      wr(`SGM_OFF_CTL_B, 8'h00);
      wr(`SGM_OFF_CNT_LOW, 8'h5a);
      check(cnt[7:0], 32'h5a, "low byte");
      c0 = cnt;
      e = n_pa + n_wa;
      wr(`SGM_OFF_STATUS, 8'h80);
      cyc(2);
      check(pcap, c0, "period capture");
      wr(`SGM_OFF_STATUS, 8'h40);
      cyc(2);
      check(wcap, c0, "width capture");
      check(n_pa + n_wa - e, 2, "capture events");
      rc(`SGM_OFF_STATUS, 8'h00, "requests done");
      $display("test capture done");
      // Counter mode on signal edges, both polarities
      for (int s = 0; s < 2; s++) begin
         wr(`SGM_OFF_CTL_B, 8'h48);
         wr(`SGM_OFF_CTL_A, 8'h80 | 8'(s << 3));
         wr(`SGM_OFF_STATUS, 8'h20);
         wr(`SGM_OFF_CTL_B, 8'hc8);
         pulse(7);
         @(posedge CLK) sig <= 1'b1;
         cyc(4);
         check(cnt, 32'(8 - s), "signal count");
         @(posedge CLK) sig <= 1'b0;
         cyc(4);
      end
      // Single period acquisition clears run bit
      wr(`SGM_OFF_CTL_A, 8'h80);
      wr(`SGM_OFF_CTL_B, 8'h82);
      e = n_pa;
      pulse(2);
      rc(`SGM_OFF_CTL_B, 8'h02, "run cleared");
      check(32'(n_pa > e), 1, "period event");
      // Window flag under both polarities
      @(posedge CLK) win <= 1'b1;
      for (int w = 0; w < 2; w++) begin
         wr(`SGM_OFF_CTL_A, 8'h80 | 8'(w << 4));
         cyc(3);
         rc(`SGM_OFF_STATUS, w ? 8'h00 : 8'h02, "window flag");
      end
      // Reserved window code reads as closed
      wr(`SGM_OFF_CTL_A, 8'h80);
      wr(`SGM_OFF_WIN_SEL, 8'h11);
      rc(`SGM_OFF_STATUS, 8'h00, "reserved window");
      wr(`SGM_OFF_WIN_SEL, 8'h00);
      wr(`SGM_OFF_CTL_A, 8'h00);
      rc(`SGM_OFF_CTL_B, 8'h02, "kept control b");
      // Capture mode on window edges
      wr(`SGM_OFF_CTL_B, 8'hc7);
      wr(`SGM_OFF_CTL_A, 8'h80);
      e = n_pa + n_wa;
      @(posedge CLK) win <= 1'b0;
      cyc(40);
      @(posedge CLK) win <= 1'b1;
      cyc(4);
      check(n_pa + n_wa - e, 2, "capture mode events");
      e = int'(pcap - wcap);
      check(32'(e >= 9 && e <= 11), 1, "capture gap");
      $display("test signals done");
      finish_test();
   end
endmodule : tb_signal_measure_timer_regs
